// file: pkg/imu_pkg.sv
// Constants, register layout and shared arithmetic of the sample chain.
// Assumes one 25 MHz core clock and a 16-bit register port with byte addresses.
package imu_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [6:0] A_GYRO_X_OFF = 7'h1a;
	localparam logic [6:0] A_GYRO_Y_OFF = 7'h1c;
	localparam logic [6:0] A_GYRO_Z_OFF = 7'h1e;
	localparam logic [6:0] A_ACC_X_OFF = 7'h20;
	localparam logic [6:0] A_ACC_Y_OFF = 7'h22;
	localparam logic [6:0] A_ACC_Z_OFF = 7'h24;
	localparam logic [6:0] A_SAMPLING = 7'h36;
	localparam logic [6:0] A_FILTER = 7'h38;
	localparam logic [6:0] A_GLOBAL_CMD = 7'h3e;
	localparam logic [15:0] SMP_RST = 16'h0001;
	localparam logic [15:0] FLT_RST = 16'h0402;
	localparam logic [15:0] SMP_MASK = 16'h1f01;
	localparam logic [15:0] ACC_YZ_MASK = 16'h3fff;
	// ----------------------------------------------------------------
	// Fields and codes
	// ----------------------------------------------------------------
	localparam int CLKSEL_BIT = 0;
	localparam int DEC_LSB = 8;
	localparam int DEC_MSB = 12;
	localparam int TAPS_MSB = 2;
	localparam int RANGE_LSB = 8;
	localparam int RANGE_MSB = 10;
	localparam int CMD_AUTO_BIAS = 0;
	localparam logic [4:0] DEC_MAX = 5'h10;
	localparam logic [2:0] RANGE_1000 = 3'h4;
	localparam logic [2:0] RANGE_500 = 3'h2;
	localparam logic [2:0] RANGE_250 = 3'h1;
	localparam logic [2:0] MIN_B_500 = 3'h2;
	localparam logic [2:0] MIN_B_250 = 3'h4;
	localparam logic [2:0] CH_ACC_X = 3'h3;
	localparam logic [2:0] CH_ACC_Y = 3'h4;
	localparam logic [2:0] CH_ACC_Z = 3'h5;
	localparam logic [2:0] CH_TEMP = 3'h6;
	localparam int MEM_AW = 11;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam real CLK_HZ = 25000000.0;
	localparam real BASE_RATE_SPS = 819.2;
	localparam int SAMPLE_DIV_CYC = $rtoi(CLK_HZ / BASE_RATE_SPS);

	function automatic logic [15:0] sat16(input logic signed [33:0] v);
		if (v > 34'sh7fff) return 16'h7fff;
		if (v < -34'sh8000) return 16'h8000;
		return v[15:0];
	endfunction : sat16

	function automatic logic [15:0] sext14(input logic [15:0] v);
		return {{2{v[13]}}, v[13:0]};
	endfunction : sext14
endpackage : imu_pkg

// file: pkg/mem_if.sv
// Port of the filter history memory between the sequencer and the memory.
// Assumes both sides run on core_clk.
interface mem_if;
	logic we;
	logic [imu_pkg::MEM_AW-1:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport ctrl (output we, output addr, output wdata, input rdata);
	modport mem (input we, input addr, input wdata, output rdata);
endinterface : mem_if

// file: rtl/sample_mem.sv
// History memory of both filter stages, one word per channel and tap.
// Assumes a single-port access per cycle; read data are registered.
module sample_mem (
	input wire logic core_clk,
	input wire logic ce,
	mem_if.mem m
);
	logic [15:0] ram [0:(1 << imu_pkg::MEM_AW)-1];

	always_ff @(posedge core_clk) begin
		if (ce) begin
			if (m.we) begin
				ram[m.addr] <= m.wdata;
			end
			m.rdata <= ram[m.addr];
		end
	end
endmodule : sample_mem

// file: rtl/sample_clock.sv
// Sampling tick source: internal divider or rising edge on line four.
// Assumes the external line is synchronous to core_clk.
module sample_clock #(
	parameter int DIV = imu_pkg::SAMPLE_DIV_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic use_internal,
	input wire logic ext_line,
	output logic tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic prev;
		logic tick;
	} clk_st_t;
	clk_st_t r, n;

	always_comb begin
		n = r;
		n.tick = 1'b0;
		n.prev = ext_line;
		if (use_internal) begin
			if (r.cnt >= 16'(DIV - 1)) begin
				n.cnt = '0;
				n.tick = 1'b1;
			end else begin
				n.cnt = r.cnt + 16'h1;
			end
		end else begin
			n.cnt = '0;
			n.tick = ext_line && !r.prev;
		end
		if (rst) n = '0;
	end

	always_ff @(posedge core_clk) begin
		if (rst || ce) r <= n;
	end

	assign tick = r.tick;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	AST_EXT_ONLY: assert property (ce && !use_internal && !(ext_line && !r.prev) |=> !tick)
		else $error("tick without external edge");
	AST_EXT_EDGE: assert property (ce && !use_internal && ext_line && !r.prev |=> tick)
		else $error("external edge lost");
	AST_INT_PERIOD: assert property (tick && $past(use_internal) && $past(ce)
		|-> $past(r.cnt) == 16'(DIV - 1))
		else $error("internal tick period wrong");
endmodule : sample_clock

// file: rtl/inertial_sample_processing.sv
// Sample chain: two-stage averaging filter, decimator, offsets, auto bias.
// Assumes sensor_in holds gyro x,y,z, accel x,y,z and temperature,
// stable from the sampling tick until the chain has taken it.
module inertial_sample_processing #(
	parameter int SAMPLE_DIV = imu_pkg::SAMPLE_DIV_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic [6:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic [6:0][15:0] sensor_in,
	input wire logic general_line_four,
	input wire logic flash_save_done,
	output logic [2:0][15:0] gyro_outputs,
	output logic [2:0][15:0] accel_outputs,
	output logic [15:0] temp_output,
	output logic data_ready,
	output logic flash_save_busy,
	output logic [2:0] gyro_range
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		S_CLR = 5'b00001,
		S_IDLE = 5'b00010,
		S_WR = 5'b00100,
		S_RD = 5'b01000,
		S_FIN = 5'b10000
	} seq_st_t;

	typedef struct packed {
		seq_st_t st;
		logic [2:0][15:0] goff;
		logic [2:0][15:0] aoff;
		logic [15:0] smp;
		logic [15:0] flt;
		logic [6:0][15:0] outv;
		logic [6:0][15:0] raw;
		logic [6:0][32:0] dacc;
		logic [15:0] dcnt;
		logic [15:0] rdata;
		logic [15:0] cur;
		logic signed [22:0] acc;
		logic [7:0] k;
		logic [6:0] ptr;
		logic [2:0] ch;
		logic stage;
		logic drdy;
		logic fbusy;
		logic [imu_pkg::MEM_AW-1:0] clr;
	} proc_st_t;
	proc_st_t r, n;

	mem_if m ();
	logic tick;
	logic [4:0] dec_d;
	logic [2:0] taps_b;
	logic [15:0] last_cnt;
	logic dec_last;
	logic signed [22:0] fin_sum;
	logic [15:0] res;
	logic signed [32:0] dsum;
	logic [15:0] dec_val;
	logic [15:0] offv;
	logic [15:0] out_val;
	logic [2:0] rng_w;
	logic [2:0] bmin;
	logic [2:0] b_w;

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	// The host keeps line four an input while external sampling is used.
	sample_clock #(.DIV(SAMPLE_DIV)) u_clk (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.use_internal(r.smp[imu_pkg::CLKSEL_BIT]),
		.ext_line(general_line_four),
		.tick(tick)
	);

	sample_mem u_mem (
		.core_clk(core_clk),
		.ce(ce),
		.m(m.mem)
	);

	// ----------------------------------------------------------------
	// Datapath
	// ----------------------------------------------------------------
	// D beyond 16 is held at 16 so the block accumulator cannot overflow.
	assign dec_d = (r.smp[imu_pkg::DEC_MSB:imu_pkg::DEC_LSB] > imu_pkg::DEC_MAX) ?
		imu_pkg::DEC_MAX : r.smp[imu_pkg::DEC_MSB:imu_pkg::DEC_LSB];
	assign taps_b = r.flt[imu_pkg::TAPS_MSB:0];
	assign last_cnt = 16'((17'h1 << dec_d) - 17'h1);
	assign dec_last = r.dcnt >= last_cnt;
	assign fin_sum = r.acc + 23'(signed'(m.rdata));
	assign res = 16'(fin_sum >>> taps_b);
	assign dsum = signed'(r.dacc[r.ch]) + 33'(signed'(res));
	assign dec_val = 16'(dsum >>> dec_d);
	assign out_val = imu_pkg::sat16(34'(signed'(dec_val)) + 34'(signed'(offv)));

	always_comb begin
		case (r.ch)
			imu_pkg::CH_ACC_X: offv = r.aoff[0];
			imu_pkg::CH_ACC_Y: offv = imu_pkg::sext14(r.aoff[1]);
			imu_pkg::CH_ACC_Z: offv = imu_pkg::sext14(r.aoff[2]);
			imu_pkg::CH_TEMP: offv = '0;
			default: offv = r.goff[r.ch[1:0]];
		endcase
	end

	// A write with an unknown range code keeps the old range.
	assign rng_w = (reg_wdata[imu_pkg::RANGE_MSB:imu_pkg::RANGE_LSB]
		inside {imu_pkg::RANGE_1000, imu_pkg::RANGE_500, imu_pkg::RANGE_250}) ?
		reg_wdata[imu_pkg::RANGE_MSB:imu_pkg::RANGE_LSB] :
		r.flt[imu_pkg::RANGE_MSB:imu_pkg::RANGE_LSB];
	assign bmin = (rng_w == imu_pkg::RANGE_250) ? imu_pkg::MIN_B_250 :
		(rng_w == imu_pkg::RANGE_500) ? imu_pkg::MIN_B_500 : 3'h0;
	assign b_w = (reg_wdata[imu_pkg::TAPS_MSB:0] < bmin) ? bmin :
		reg_wdata[imu_pkg::TAPS_MSB:0];

	// ----------------------------------------------------------------
	// Sequencer and registers
	// ----------------------------------------------------------------
	// Each channel is filtered by reading back its whole history, so a tick
	// that arrives while the chain is busy is dropped. The worst case of
	// about 1.8k cycles stays well inside either sample period.
	always_comb begin
		n = r;
		m.we = 1'b0;
		m.addr = {r.stage, r.ch, 7'(r.ptr - r.k[6:0])};
		m.wdata = r.stage ? r.cur : r.raw[r.ch];
		case (r.st)
			S_CLR: begin
				m.we = 1'b1;
				m.addr = r.clr;
				m.wdata = '0;
				n.clr = r.clr + 1'b1;
				if (&r.clr) n.st = S_IDLE;
			end
			S_IDLE: begin
				if (tick) begin
					n.raw = sensor_in;
					n.ch = '0;
					n.stage = 1'b0;
					n.st = S_WR;
				end
			end
			S_WR: begin
				m.we = 1'b1;
				m.addr = {r.stage, r.ch, r.ptr};
				n.acc = '0;
				n.k = '0;
				n.st = S_RD;
			end
			S_RD: begin
				if (r.k != 8'h0) n.acc = fin_sum;
				n.k = r.k + 8'h1;
				if (r.k == (8'h1 << taps_b) - 8'h1) n.st = S_FIN;
			end
			S_FIN: begin
				if (!r.stage) begin
					// The first average feeds a second one of equal length.
					n.cur = res;
					n.stage = 1'b1;
					n.st = S_WR;
				end else begin
					n.stage = 1'b0;
					n.dacc[r.ch] = dec_last ? '0 : 33'(dsum);
					// Offsets are added on the way into the output word.
					if (dec_last) n.outv[r.ch] = out_val;
					if (r.ch == imu_pkg::CH_TEMP) begin
						n.ch = '0;
						n.ptr = r.ptr + 7'h1;
						n.dcnt = dec_last ? '0 : r.dcnt + 16'h1;
						if (dec_last && !r.fbusy) n.drdy = !r.drdy;
						n.st = S_IDLE;
					end else begin
						n.ch = r.ch + 3'h1;
						n.st = S_WR;
					end
				end
			end
			default: n.st = S_IDLE;
		endcase

		// The end of a save is taken first so that a new bias command wins.
		if (flash_save_done) n.fbusy = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				imu_pkg::A_GYRO_X_OFF: n.goff[0] = reg_wdata;
				imu_pkg::A_GYRO_Y_OFF: n.goff[1] = reg_wdata;
				imu_pkg::A_GYRO_Z_OFF: n.goff[2] = reg_wdata;
				imu_pkg::A_ACC_X_OFF: n.aoff[0] = reg_wdata;
				imu_pkg::A_ACC_Y_OFF: n.aoff[1] = reg_wdata & imu_pkg::ACC_YZ_MASK;
				imu_pkg::A_ACC_Z_OFF: n.aoff[2] = reg_wdata & imu_pkg::ACC_YZ_MASK;
				imu_pkg::A_SAMPLING: n.smp = reg_wdata & imu_pkg::SMP_MASK;
				imu_pkg::A_FILTER: begin
					n.flt = ({13'h0, rng_w} << imu_pkg::RANGE_LSB) | {13'h0, b_w};
				end
				imu_pkg::A_GLOBAL_CMD: begin
					if (reg_wdata[imu_pkg::CMD_AUTO_BIAS]) begin
						for (int i = 0; i < 3; i++) begin
							n.goff[i] = imu_pkg::sat16(-34'(signed'(r.outv[i])));
						end
						n.fbusy = 1'b1;
					end
				end
				default: ;
			endcase
		end

		case (reg_addr)
			imu_pkg::A_GYRO_X_OFF: n.rdata = r.goff[0];
			imu_pkg::A_GYRO_Y_OFF: n.rdata = r.goff[1];
			imu_pkg::A_GYRO_Z_OFF: n.rdata = r.goff[2];
			imu_pkg::A_ACC_X_OFF: n.rdata = r.aoff[0];
			imu_pkg::A_ACC_Y_OFF: n.rdata = r.aoff[1];
			imu_pkg::A_ACC_Z_OFF: n.rdata = r.aoff[2];
			imu_pkg::A_SAMPLING: n.rdata = r.smp;
			imu_pkg::A_FILTER: n.rdata = r.flt;
			default: n.rdata = '0;
		endcase

		if (rst) begin
			n = '0;
			n.st = S_CLR;
			n.smp = imu_pkg::SMP_RST;
			n.flt = imu_pkg::FLT_RST;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || ce) r <= n;
	end

	assign reg_rdata = r.rdata;
	assign gyro_outputs = r.outv[2:0];
	assign accel_outputs = r.outv[5:3];
	assign temp_output = r.outv[6];
	assign data_ready = r.drdy;
	assign flash_save_busy = r.fbusy;
	assign gyro_range = r.flt[imu_pkg::RANGE_MSB:imu_pkg::RANGE_LSB];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence seq_bias_cmd;
		ce && reg_wr && reg_addr == imu_pkg::A_GLOBAL_CMD
			&& reg_wdata[imu_pkg::CMD_AUTO_BIAS];
	endsequence
	sequence seq_last_out;
		ce && r.st == S_FIN && r.stage && r.ch == imu_pkg::CH_TEMP
			&& dec_d == 5'h0 && !r.fbusy;
	endsequence

	AST_RANGE_MIN: assert property (ce && reg_wr && reg_addr == imu_pkg::A_FILTER
		&& reg_wdata[imu_pkg::RANGE_MSB:imu_pkg::RANGE_LSB] == imu_pkg::RANGE_250
		|=> r.flt[imu_pkg::TAPS_MSB:0] >= imu_pkg::MIN_B_250)
		else $error("filter size below range minimum");
	AST_AUTO_BIAS: assert property (seq_bias_cmd |=>
		r.goff[0] == imu_pkg::sat16(-34'(signed'($past(r.outv[0])))) && flash_save_busy)
		else $error("bias command did not load negated output");
	AST_DRDY_HOLD: assert property (flash_save_busy |=> $stable(data_ready))
		else $error("data ready toggled during save");
	AST_DEC_PASS: assert property (seq_last_out |=> data_ready != $past(data_ready))
		else $error("undecimated sample did not toggle data ready");
	AST_TWO_STAGE: assert property (ce && r.st == S_FIN && !r.stage
		|=> r.st == S_WR && r.stage)
		else $error("second filter stage skipped");
	AST_YZ_UNUSED: assert property (r.aoff[1][15:14] == 2'h0 && r.aoff[2][15:14] == 2'h0)
		else $error("unused accel offset bits set");

	// ----------------------------------------------------------------
	// Update timing checks, filter range minimum and unused sampling bits
	// ----------------------------------------------------------------
	// Data ready may only move when the last channel closes; each output word moves when its own channel
	// closes, so a host reading while a set is being processed can see a half-updated set.
	sequence seq_set_close;
		ce && r.st == S_FIN && r.stage && r.ch == imu_pkg::CH_TEMP;
	endsequence

	AST_DRDY_AT_CLOSE: assert property (!(ce && r.st == S_FIN && r.stage
		&& r.ch == imu_pkg::CH_TEMP) |=> $stable(data_ready))
		else $error("data ready moved outside set close");
	AST_TEMP_HOLD: assert property (!(ce && r.st == S_FIN && r.stage && dec_last)
		|=> $stable(temp_output))
		else $error("temperature moved inside a decimation block");
	AST_BLOCK_TOGGLE: assert property (seq_set_close ##0 (dec_last && !r.fbusy)
		|=> data_ready != $past(data_ready))
		else $error("full decimation block did not toggle data ready");
	AST_RANGE_MIN_500: assert property (ce && reg_wr && reg_addr == imu_pkg::A_FILTER
		&& reg_wdata[imu_pkg::RANGE_MSB:imu_pkg::RANGE_LSB] == imu_pkg::RANGE_500
		|=> r.flt[imu_pkg::TAPS_MSB:0] >= imu_pkg::MIN_B_500)
		else $error("filter size below medium range minimum");
	// Unused sampling bits must read back as zero whatever the host wrote.
	AST_SMP_UNUSED: assert property ((r.smp & ~imu_pkg::SMP_MASK) == 16'h0000)
		else $error("unused sampling bits set");
endmodule : inertial_sample_processing

// file: sim/flash_store_model.sv
// Stand-in for the nonvolatile store behind the sample chain.
// Assumes busy is a registered level on core_clk; DELAY sets how slow the store answers.
module flash_store_model #(
	parameter int DELAY = 400
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic flash_save_busy,
	output logic flash_save_done
);
	timeunit 1ns;
	timeprecision 1ps;
	int count = 0;
	initial flash_save_done = 1'b0;
	// ----------------------------------------------------------------
	// Save timing
	// ----------------------------------------------------------------
	// Done is only ever sent for a pending save, so a stuck busy cannot be hidden.
	always @(posedge core_clk) begin
		flash_save_done <= 1'b0;
		if (rst || !flash_save_busy) begin
			count <= 0;
		end else if (count <= DELAY) begin
			count <= count + 1;
			flash_save_done <= (count == DELAY);
		end
	end
endmodule : flash_store_model

// file: sim/test_inertial_sample_processing.sv
// Self-checking bench of the sample chain: registers, filter, decimator, offsets, bias.
// Assumes the package, interface, design files and the flash store model compile first.
module test_inertial_sample_processing;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DIV = 200;
	localparam logic [6:0] RA [10] = '{7'h1a, 7'h1c, 7'h1e, 7'h20, 7'h22, 7'h24, 7'h36, 7'h38,
		7'h3e, 7'h30};
	localparam logic [15:0] RV [10] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0001,
		16'h0402, 16'h0, 16'h0};
	localparam logic [15:0] TRI [3] = '{16'h0100, 16'h0300, 16'h0400};
	typedef logic [6:0][15:0] words_t;
	logic core_clk;
	logic rst;
	logic reg_wr;
	logic [6:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic [6:0][15:0] sensor_in;
	logic general_line_four;
	logic flash_save_done;
	logic [2:0][15:0] gyro_outputs;
	logic [2:0][15:0] accel_outputs;
	logic [15:0] temp_output;
	logic data_ready;
	logic flash_save_busy;
	logic [2:0] gyro_range;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	int toggles = 0;
	int last_cyc = 0;
	bit chk_rate = 1'b0;
	logic dr_prev = 1'b0;
	logic [31:0] seed = 32'h00008e28;
	logic [15:0] offs [7];
	logic [15:0] v;
	words_t exp_q [$];
	words_t want, seen, s, a, b, last;

	inertial_sample_processing #(.SAMPLE_DIV(DIV)) uut (.core_clk(core_clk), .rst(rst),
		.ce(1'b1), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .sensor_in(sensor_in), .general_line_four(general_line_four),
		.flash_save_done(flash_save_done), .gyro_outputs(gyro_outputs),
		.accel_outputs(accel_outputs), .temp_output(temp_output), .data_ready(data_ready),
		.flash_save_busy(flash_save_busy), .gyro_range(gyro_range));
	flash_store_model #(.DELAY(400)) store (.core_clk(core_clk), .rst(rst),
		.flash_save_busy(flash_save_busy), .flash_save_done(flash_save_done));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : rnd

	function automatic logic [15:0] sat(input int x);
		if (x > 32767) return 16'h7fff;
		if (x < -32768) return 16'h8000;
		return x[15:0];
	endfunction : sat

	function automatic words_t expect_of(input words_t w);
		words_t e;
		for (int i = 0; i < 7; i++) e[i] = sat(int'($signed(w[i])) + int'($signed(offs[i])));
		return e;
	endfunction : expect_of

	task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask : check

	task automatic end_sim();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	task automatic wr(input logic [6:0] ad, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [6:0] ad, input logic [15:0] e);
		@(posedge core_clk);
		reg_addr <= ad;
		repeat (2) @(posedge core_clk);
		#1;
		check("register read", e, reg_rdata);
	endtask : rd

	task automatic wait_dr(input int n);
		int t;
		t = toggles + n;
		for (int i = 0; i < 5000 && toggles < t; i++) @(posedge core_clk);
		if (toggles < t) check("update wait", 16'h1, 16'h0);
	endtask : wait_dr

	// One external sampling edge, then room for the chain to finish.
	task automatic ext_tick();
		@(posedge core_clk);
		general_line_four <= 1'b1;
		repeat (4) @(posedge core_clk);
		general_line_four <= 1'b0;
		repeat (300) @(posedge core_clk);
	endtask : ext_tick

	// ----------------------------------------------------------------
	// Clock, timeout and output watcher
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			end_sim();
		end
	end

	always @(negedge core_clk) begin
		if (!rst && data_ready !== dr_prev) begin
			toggles++;
			if (chk_rate) check("update spacing", 16'(DIV), 16'(cyc - last_cyc));
			last_cyc = cyc;
			seen = {temp_output, accel_outputs, gyro_outputs};
			if (exp_q.size() == 0) begin
				check("update count", 16'h0, 16'h1);
			end else begin
				want = exp_q.pop_front();
				for (int i = 0; i < 7; i++) check("output word", want[i], seen[i]);
			end
		end
		dr_prev = data_ready;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_addr = 7'h00;
		reg_wdata = 16'h0000;
		sensor_in = '0;
		general_line_four = 1'b0;
		foreach (offs[i]) offs[i] = 16'h0000;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		foreach (RA[i]) rd(RA[i], RV[i]);
		check("range", 16'h0004, {13'h0, gyro_range});
		wr(7'h38, 16'h0100);
		rd(7'h38, 16'h0104);
		check("range", 16'h0001, {13'h0, gyro_range});
		wr(7'h38, 16'h0200);
		rd(7'h38, 16'h0202);
		wr(7'h38, 16'h0301);
		rd(7'h38, 16'h0202);
		wr(7'h38, 16'h0401);
		rd(7'h38, 16'h0401);
		wr(7'h22, 16'hffff);
		rd(7'h22, 16'h3fff);
		offs[4] = 16'hffff;
		wr(7'h36, 16'hffff);
		rd(7'h36, 16'h1f01);
		wr(7'h36, 16'h0001);
		wr(7'h30, 16'h1234);
		rd(7'h30, 16'h0000);
		// Constant input through two 2-tap stages ramps 1/4, 3/4, then full scale.
		sensor_in <= {7{16'h0400}};
		foreach (TRI[k]) begin
			s = {7{TRI[k]}};
			exp_q.push_back(expect_of(s));
		end
		wait_dr(1);
		chk_rate = 1'b1;
		wait_dr(2);
		chk_rate = 1'b0;
		wr(7'h36, 16'h0000);
		wr(7'h38, 16'h0400);
		for (int i = 0; i < 6; i++) begin
			v = rnd();
			wr(RA[i], v);
			offs[i] = (i > 3) ? {{2{v[13]}}, v[13:0]} : v;
		end
		for (int n = 0; n < 3; n++) begin
			foreach (s[i]) s[i] = rnd();
			sensor_in <= s;
			exp_q.push_back(expect_of(s));
			ext_tick();
		end
		wr(7'h36, 16'h0100);
		for (int n = 0; n < 2; n++) begin
			foreach (a[i]) a[i] = rnd();
			foreach (b[i]) b[i] = rnd();
			foreach (s[i]) s[i] = 16'((int'($signed(a[i])) + int'($signed(b[i]))) >>> 1);
			last = expect_of(s);
			exp_q.push_back(last);
			sensor_in <= a;
			ext_tick();
			sensor_in <= b;
			ext_tick();
		end
		// Back to one output per sample, so the tick during the save would toggle.
		wr(7'h36, 16'h0000);
		wr(7'h3e, 16'h0001);
		#1;
		check("save busy", 16'h0001, {15'h0, flash_save_busy});
		ext_tick();
		for (int i = 0; i < 2000 && flash_save_busy !== 1'b0; i++) @(posedge core_clk);
		repeat (300) @(posedge core_clk);
		check("save busy", 16'h0000, {15'h0, flash_save_busy});
		for (int i = 0; i < 3; i++) rd(RA[i], sat(-int'($signed(last[i]))));
		check("pending updates", 16'h0000, 16'(exp_q.size()));
		end_sim();
	end
endmodule : test_inertial_sample_processing
